/* rtl/scc_channel_setup.sv */
// satellite channel setup, frame check and data word buffer
//
// Function
// - checksum off: no parity bit, received check bits follow the data bits
// - manchester mode: setup bit D11 low checks, high skips checksum; psi5 ignores it
// - length field applies to protocol A, B and psi5 channels, code 00 used for other modes
// - checksum off: no checksum check on incoming message, length and rate still checked, check bits kept in report
// - protocol A lengths 18/16/15/13, reports 13/11/10/8 or 16/14/13/11
// - protocol B lengths 16/14/13/11, reports 13/11/10/8 or 14/12/11/9
// - psi5: checksum always checked, D11 ignored, no received parity in word
// - psi5 lengths 16/14/13/11, reports 13/11/10/8, code 00 default
// - speed field picks accepted bit-rate window per channel
// - speed field resets to fastest window code 00
// - enable decode: 00 off, 01 and 11 satellite only, 10 both on
// - word empty for 00/11, decoded data for 10, inverted raw level in D0 for 01 on channels 0 and 1 only
// - current input deglitched before decoding, optional hysteresis on threshold
// - three-bit threshold code per channel, 000 lowest and default
// - decoded word content valid only with status 000, 001 or 101
// - status 000 one good, 001 good with loss, 101 good with leakage
`timescale 1ns/1ns
module scc_channel_setup
	import scc_pkg::*;
(
	// clock and reset
	input  wire logic             sys_clk,
	input  wire logic             rst,
	// setup command
	input  wire logic             cmd_valid,
	input  wire logic [1:0]       cmd_chan,
	input  wire logic [15:0]      cmd_word,
	output logic                  cmd_ready,
	// mode register fields per channel
	input  wire logic [3:0][3:0]  mode_sel,
	// analog front end
	input  wire logic [3:0]       cur_above,
	input  wire logic [3:0]       cur_above_hyst,
	input  wire logic [3:0]       leak_supply,
	output logic      [3:0]       sat_on,
	output logic      [3:0]       dec_on,
	output logic      [3:0]       hyst_on,
	output logic      [3:0][2:0]  thr_code,
	output logic      [3:0][1:0]  speed_code,
	// decoded frames
	input  wire logic             rx_valid,
	input  wire logic [1:0]       rx_chan,
	input  wire logic [MSG_W-1:0] rx_bits,
	input  wire logic [4:0]       rx_len,
	input  wire logic [15:0]      rx_period,
	output logic                  rx_ready,
	// data words
	output logic                  dw_valid,
	input  wire logic             dw_ready,
	output logic      [1:0]       dw_chan,
	output logic      [2:0]       dw_status,
	output logic      [15:0]      dw_word
);

	// ========================================
	// functions
	function automatic scc_prot_e prot_of(input logic [3:0] m);
		scc_prot_e p;
		unique case (m)
			MODE_PROT_A: p = PR_A;
			MODE_PROT_B: p = PR_B;
			MODE_PSI5:   p = PR_PSI5;
			default:     p = PR_OTHER;
		endcase
		return p;
	endfunction

	function automatic logic [2:0] crc3(input logic [MSG_W-1:0] d, input logic [4:0] n);
		logic [2:0] r;
		logic       fb;
		r = CRC_SEED;
		fb = 1'b0;
		for (int i = MSG_W - 1; i >= 0; i--) begin
			if (i < int'(n)) begin
				fb = r[2] ^ d[i];
				r = {r[1:0], 1'b0} ^ (fb ? CRC_POLY : 3'h0);
			end
		end
		return r;
	endfunction

	// ========================================
	// declarations
	logic [CFG_W-1:0] cfg_reg [4];
	logic [2:0]       s1_reg [4];
	logic [2:0]       s2_reg [4];
	logic [2:0]       s3_reg [4];
	logic [2:0]       stab_reg [4];
	logic [DG_W-1:0]  dg_cnt_reg [4];
	logic [3:0]       lvl_reg;
	logic [3:0]       lvl_flip;
	logic [3:0]       raw_pend_reg;
	logic [3:0]       lost_reg;
	logic [ENT_W-1:0] mem_reg [2];
	logic             wr_ptr_reg;
	logic             rd_ptr_reg;
	logic [1:0]       cnt_reg;

	logic [CFG_W-1:0] c;
	scc_prot_e        pr;
	logic [1:0]       lc;
	logic             off;
	logic [4:0]       msg_len;
	logic [4:0]       rep;
	logic [MSG_W-1:0] data;
	logic [31:0]      w_al;
	logic             len_ok;
	logic             chk_ok;
	logic             rate_ok;
	logic             frame_ok;
	logic [2:0]       rx_status;
	logic [15:0]      rx_word;
	logic             in_ready;
	logic             rx_take;
	logic             rx_push;
	logic             raw_push;
	logic [1:0]       raw_ch;
	logic [ENT_W-1:0] ent;
	logic             pop;

	// ========================================
	// channel setup registers
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			for (int i = 0; i < 4; i++) begin
				cfg_reg[i] <= CFG_RESET;
			end
		end else if (cmd_valid) begin
			cfg_reg[cmd_chan] <= cmd_word[CFG_W-1:0];
		end
	end

	assign cmd_ready = 1'b1;

	generate
		for (genvar g = 0; g < 4; g++) begin : g_cfg
			// 00 off, 01/11 satellite only, 10 both
			assign sat_on[g]     = cfg_reg[g][F_EN_HI:F_EN_LO] != EN_OFF;
			assign dec_on[g]     = cfg_reg[g][F_EN_HI:F_EN_LO] == EN_DEC;
			assign hyst_on[g]    = cfg_reg[g][F_HYST];
			assign thr_code[g]   = cfg_reg[g][F_THR_HI:F_THR_LO];
			assign speed_code[g] = cfg_reg[g][F_SPD_HI:F_SPD_LO];
		end
	endgenerate

	// ========================================
	// input synchronisers and deglitch filter
	generate
		for (genvar g = 0; g < 4; g++) begin : g_dg
			logic tgt;
			always_ff @(posedge sys_clk) begin
				if (rst) begin
					s1_reg[g]   <= 3'h0;
					s2_reg[g]   <= 3'h0;
					s3_reg[g]   <= 3'h0;
					stab_reg[g] <= 3'h0;
				end else begin
					s1_reg[g] <= {leak_supply[g], cur_above_hyst[g], cur_above[g]};
					s2_reg[g] <= s1_reg[g];
					s3_reg[g] <= s2_reg[g];
					for (int b = 0; b < 3; b++) begin
						if (s2_reg[g][b] == s3_reg[g][b]) begin
							stab_reg[g][b] <= s3_reg[g][b];
						end
					end
				end
			end
			// rise on upper comparator with hysteresis on, else lower one; fall on lower one
			assign tgt = (hyst_on[g] && !lvl_reg[g]) ? stab_reg[g][1] : stab_reg[g][0];
			assign lvl_flip[g] = (tgt != lvl_reg[g]) && (dg_cnt_reg[g] == DG_W'(DEGLITCH_CYC - 1));
			always_ff @(posedge sys_clk) begin
				if (rst) begin
					dg_cnt_reg[g] <= '0;
					lvl_reg[g]    <= 1'b0;
				end else if (tgt == lvl_reg[g]) begin
					dg_cnt_reg[g] <= '0;
				end else if (dg_cnt_reg[g] == DG_W'(DEGLITCH_CYC - 1)) begin
					dg_cnt_reg[g] <= '0;
					lvl_reg[g]    <= tgt;
				end else begin
					dg_cnt_reg[g] <= dg_cnt_reg[g] + DG_W'(1);
				end
			end
		end
	endgenerate

	// ========================================
	// frame check and word formatting
	always_comb begin
		c = cfg_reg[rx_chan];
		pr = prot_of(mode_sel[rx_chan]);
		lc = (pr == PR_OTHER) ? 2'h0 : c[F_LEN_HI:F_LEN_LO];
		off = (pr != PR_PSI5) && c[F_CRC_OFF];
		msg_len = (pr == PR_A) ? A_MSG[lc] : B_MSG[lc];
		if (!off) begin
			rep = REP_ON[lc];
		end else if (pr == PR_A) begin
			rep = A_OFF[lc];
		end else begin
			rep = B_OFF[lc];
		end
		if (off) begin
			data = rx_bits;
		end else begin
			data = rx_bits >> ((pr == PR_A) ? CHK_A : CHK_P);
		end
		data = data & ((MSG_W'(1) << rep) - MSG_W'(1));
		len_ok = rx_len == msg_len;
		if (off) begin
			chk_ok = 1'b1;
		end else if (pr == PR_A) begin
			chk_ok = crc3(data, rep) == rx_bits[2:0];
		end else begin
			chk_ok = ~^(rx_bits & ((MSG_W'(1) << 5'(rep + 5'h1)) - MSG_W'(1)));
		end
		rate_ok = int'(rx_period) >= BIT_MIN_CYC[c[F_SPD_HI:F_SPD_LO]] &&
			int'(rx_period) <= BIT_MAX_CYC[c[F_SPD_HI:F_SPD_LO]];
		frame_ok = len_ok && chk_ok && rate_ok;
		w_al = {14'h0, data} << (off ? WORD_LEN - rep : WORD_LEN - 5'h1 - rep);
		if (!frame_ok) begin
			rx_word = 16'h0;
		end else if (off) begin
			rx_word = w_al[15:0];
		end else begin
			rx_word = {~^w_al[14:0], w_al[14:0]};
		end
		if (!frame_ok) begin
			rx_status = stab_reg[rx_chan][2] ? ST_LEAK_BAD : ST_BAD;
		end else if (stab_reg[rx_chan][2]) begin
			rx_status = ST_LEAK_GOOD;
		end else begin
			rx_status = lost_reg[rx_chan] ? ST_LOST : ST_GOOD;
		end
	end

	// ========================================
	// push selection
	assign in_ready = cnt_reg != 2'h2;
	assign rx_ready = in_ready;
	assign rx_take  = rx_valid && rx_ready;
	assign rx_push  = rx_take && dec_on[rx_chan];
	assign raw_ch   = raw_pend_reg[0] ? 2'h0 : 2'h1;
	assign raw_push = !rx_push && in_ready && raw_pend_reg[raw_ch];
	assign pop      = dw_valid && dw_ready;

	always_comb begin
		if (rx_push) begin
			ent = {rx_chan, rx_status, rx_word};
		end else begin
			ent = {raw_ch, stab_reg[raw_ch][2] ? ST_LEAK_BAD : ST_EMPTY, 15'h0,
				~lvl_reg[raw_ch]};
		end
	end

	// ========================================
	// lost frames and raw level changes
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			lost_reg <= 4'h0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (rx_valid && !rx_ready && rx_chan == 2'(i)) begin
					lost_reg[i] <= 1'b1;
				end else if (rx_push && frame_ok && rx_chan == 2'(i)) begin
					lost_reg[i] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			raw_pend_reg <= 4'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (cfg_reg[i][F_EN_HI:F_EN_LO] == EN_SAT && lvl_flip[i]) begin
					raw_pend_reg[i] <= 1'b1;
				end else if (raw_push && raw_ch == 2'(i)) begin
					raw_pend_reg[i] <= 1'b0;
				end
			end
		end
	end

	// ========================================
	// two-entry word buffer
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wr_ptr_reg <= 1'b0;
			rd_ptr_reg <= 1'b0;
			cnt_reg    <= 2'h0;
		end else begin
			if (rx_push || raw_push) begin
				mem_reg[wr_ptr_reg] <= ent;
				wr_ptr_reg <= !wr_ptr_reg;
			end
			if (pop) begin
				rd_ptr_reg <= !rd_ptr_reg;
			end
			cnt_reg <= cnt_reg + 2'((rx_push || raw_push) ? 1 : 0) - 2'(pop ? 1 : 0);
		end
	end

	assign dw_valid  = cnt_reg != 2'h0;
	assign dw_chan   = dw_valid ? mem_reg[rd_ptr_reg][ENT_W-1 -: 2] : 2'h0;
	assign dw_status = dw_valid ? mem_reg[rd_ptr_reg][WORD_W +: 3] : ST_EMPTY;
	assign dw_word   = dw_valid ? mem_reg[rd_ptr_reg][WORD_W-1:0] : 16'h0;

	// ========================================
	// assertions
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	cfg_write_a: assert property (
		cmd_valid |=> cfg_reg[$past(cmd_chan)] == $past(cmd_word[CFG_W-1:0]))
		else $error("setup command not stored");
	cfg_other_a: assert property (
		cmd_valid && cmd_chan != 2'h0 |=> $stable(cfg_reg[0]))
		else $error("unaddressed channel setup changed");
	speed_reset_a: assert property (
		$fell(rst) |-> speed_code == '0 && thr_code == '0 && dec_on == 4'h0)
		else $error("setup not at defaults after reset");
	crc_off_a: assert property (
		rx_push && off && frame_ok && cnt_reg == 2'h0 |=>
			$countones(dw_word) == $countones($past(data)))
		else $error("parity bit added with checksum off");
	psi5_par_a: assert property (
		rx_push && pr == PR_PSI5 && frame_ok && cnt_reg == 2'h0 |=>
			dw_word[15] == ~^dw_word[14:0])
		else $error("psi5 word parity wrong");
	len_bad_a: assert property (
		rx_push && !len_ok && cnt_reg == 2'h0 |=>
			dw_word == 16'h0 && (dw_status == ST_BAD || dw_status == ST_LEAK_BAD))
		else $error("wrong length not reported");
	no_dec_a: assert property (
		rx_take && !dec_on[rx_chan] && !raw_push |=> $stable(cnt_reg) || $past(pop))
		else $error("frame buffered with decoder off");
	deglitch_a: assert property (
		$changed(lvl_reg[0]) |-> $past(dg_cnt_reg[0]) == DG_W'(DEGLITCH_CYC - 1))
		else $error("level changed before deglitch time");
	full_stall_a: assert property (
		cnt_reg == 2'h2 |-> !rx_ready ##1 cnt_reg != 2'h0)
		else $error("full buffer not stalling");

	good_frame_c: cover property (rx_push && frame_ok ##1 dw_valid);
	lost_frame_c: cover property (rx_valid && !rx_ready ##[1:20] rx_push && frame_ok);
	raw_word_c: cover property (raw_push);
	buf_full_c: cover property (cnt_reg == 2'h2 && !dw_ready);

endmodule

/* rtl/scc_pkg.sv */
// constants for the satellite channel setup block
package scc_pkg;

	// ========================================
	// clock and timing
	localparam int CLK_HZ        = 50_000_000;
	localparam int CLK_PERIOD_NS = 20;
	localparam int DEGLITCH_NS   = 1000;
	localparam int DEGLITCH_CYC  = (DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DG_W          = 6;

	// ========================================
	// setup command fields
	localparam int CFG_W     = 12;
	localparam int F_CRC_OFF = 11;
	localparam int F_LEN_HI  = 10;
	localparam int F_LEN_LO  = 9;
	localparam int F_SPD_HI  = 7;
	localparam int F_SPD_LO  = 6;
	localparam int F_EN_HI   = 5;
	localparam int F_EN_LO   = 4;
	localparam int F_HYST    = 3;
	localparam int F_THR_HI  = 2;
	localparam int F_THR_LO  = 0;
	localparam logic [CFG_W-1:0] CFG_RESET = 12'h000;

	// enable codes
	localparam logic [1:0] EN_OFF  = 2'h0;
	localparam logic [1:0] EN_SAT  = 2'h1;
	localparam logic [1:0] EN_DEC  = 2'h2;
	localparam logic [1:0] EN_SAT2 = 2'h3;

	// mode select codes
	localparam logic [3:0] MODE_PROT_A = 4'h1;
	localparam logic [3:0] MODE_PROT_B = 4'h2;
	localparam logic [3:0] MODE_PSI5   = 4'h3;
	typedef enum logic [1:0] {PR_A, PR_B, PR_PSI5, PR_OTHER} scc_prot_e;

	// channel status codes
	localparam logic [2:0] ST_GOOD      = 3'h0;
	localparam logic [2:0] ST_LOST      = 3'h1;
	localparam logic [2:0] ST_EMPTY     = 3'h2;
	localparam logic [2:0] ST_BAD       = 3'h3;
	localparam logic [2:0] ST_LEAK_BAD  = 3'h4;
	localparam logic [2:0] ST_LEAK_GOOD = 3'h5;

	// ========================================
	// message and report lengths, index = length code
	localparam int MSG_W = 18;
	localparam int WORD_W = 16;
	localparam logic [4:0] WORD_LEN = 5'h10;
	localparam logic [3:0][4:0] A_MSG   = {5'h0d, 5'h0f, 5'h10, 5'h12};
	localparam logic [3:0][4:0] A_OFF   = {5'h0b, 5'h0d, 5'h0e, 5'h10};
	localparam logic [3:0][4:0] B_MSG   = {5'h0b, 5'h0d, 5'h0e, 5'h10};
	localparam logic [3:0][4:0] B_OFF   = {5'h09, 5'h0b, 5'h0c, 5'h0e};
	localparam logic [3:0][4:0] REP_ON  = {5'h08, 5'h0a, 5'h0b, 5'h0d};
	localparam logic [4:0] CHK_A = 5'h3;
	localparam logic [4:0] CHK_P = 5'h1;
	localparam logic [2:0] CRC_POLY = 3'h3;
	localparam logic [2:0] CRC_SEED = 3'h5;

	// ========================================
	// bit-rate windows
	localparam int SPD_FMAX_HZ [4] = '{238660, 158970, 106040, 51250};
	localparam int SPD_FMIN_HZ [4] = '{62660, 43500, 26320, 13300};
	localparam int BIT_MIN_CYC [4] = '{
		(CLK_HZ + SPD_FMAX_HZ[0] - 1) / SPD_FMAX_HZ[0],
		(CLK_HZ + SPD_FMAX_HZ[1] - 1) / SPD_FMAX_HZ[1],
		(CLK_HZ + SPD_FMAX_HZ[2] - 1) / SPD_FMAX_HZ[2],
		(CLK_HZ + SPD_FMAX_HZ[3] - 1) / SPD_FMAX_HZ[3]};
	localparam int BIT_MAX_CYC [4] = '{
		CLK_HZ / SPD_FMIN_HZ[0], CLK_HZ / SPD_FMIN_HZ[1],
		CLK_HZ / SPD_FMIN_HZ[2], CLK_HZ / SPD_FMIN_HZ[3]};

	// buffered entry {chan, status, word}
	localparam int ENT_W = 2 + 3 + WORD_W;

endpackage

/* tb/scc_sat_model.sv */
// frame source standing in for the satellite decoder side
`timescale 1ns/1ns
module scc_sat_model
	import scc_pkg::*;
(
	// clock and reset
	input  wire logic             sys_clk,
	input  wire logic             rst,
	// request from bench
	input  wire logic             req,
	input  wire logic [1:0]       f_chan,
	input  wire logic [MSG_W-1:0] f_bits,
	input  wire logic [4:0]       f_len,
	input  wire logic [15:0]      f_per,
	// frame port
	input  wire logic             rx_ready,
	output logic                  rx_valid,
	output logic      [1:0]       rx_chan,
	output logic      [MSG_W-1:0] rx_bits,
	output logic      [4:0]       rx_len,
	output logic      [15:0]      rx_period
);
	// ========================================
	// hold frame until taken, then scramble bits
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rx_valid  <= 1'b0;
			rx_chan   <= 2'h0;
			rx_bits   <= '0;
			rx_len    <= 5'h00;
			rx_period <= 16'h0000;
		end else if (rx_valid && rx_ready) begin
			rx_valid <= 1'b0;
			rx_bits  <= ~rx_bits;
		end else if (req && !rx_valid) begin
			rx_valid  <= 1'b1;
			rx_chan   <= f_chan;
			rx_bits   <= f_bits;
			rx_len    <= f_len;
			rx_period <= f_per;
		end
	end
endmodule

/* tb/scc_channel_setup_test.sv */
// self-checking bench for the satellite channel setup block
`timescale 1ns/1ns
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_total++; \
	$display("ERROR %s exp %h got %h", n, e, g); end end
module scc_channel_setup_test
	import scc_pkg::*;
;
	// ========================================
	// signals
	logic                  sys_clk = 0, rst = 1, cmd_valid = 0, dw_ready = 0, req = 0;
	logic                  cmd_ready, rx_ready, rx_valid, dw_valid;
	logic      [1:0]       cmd_chan = 0, f_chan = 0, rx_chan, dw_chan;
	logic      [15:0]      cmd_word = 0, f_per = 0, rx_period, dw_word;
	logic      [3:0][3:0]  mode_sel = {4'h0, MODE_PSI5, MODE_PROT_A, MODE_PROT_B};
	logic      [3:0]       cur_above = 0, cur_above_hyst = 0, leak_supply = 0;
	logic      [3:0]       sat_on, dec_on, hyst_on;
	logic      [3:0][2:0]  thr_code;
	logic      [3:0][1:0]  speed_code;
	logic      [MSG_W-1:0] f_bits = 0, rx_bits;
	logic      [4:0]       f_len = 0, rx_len;
	logic      [2:0]       dw_status;
	int                    err_total = 0, compares = 0;

	scc_channel_setup scc_channel_setup_inst (.sys_clk(sys_clk), .rst(rst),
		.cmd_valid(cmd_valid), .cmd_chan(cmd_chan), .cmd_word(cmd_word),
		.cmd_ready(cmd_ready), .mode_sel(mode_sel), .cur_above(cur_above),
		.cur_above_hyst(cur_above_hyst), .leak_supply(leak_supply), .sat_on(sat_on),
		.dec_on(dec_on), .hyst_on(hyst_on), .thr_code(thr_code), .speed_code(speed_code),
		.rx_valid(rx_valid), .rx_chan(rx_chan), .rx_bits(rx_bits), .rx_len(rx_len),
		.rx_period(rx_period), .rx_ready(rx_ready), .dw_valid(dw_valid),
		.dw_ready(dw_ready), .dw_chan(dw_chan), .dw_status(dw_status), .dw_word(dw_word));
	scc_sat_model scc_sat_model_inst (.sys_clk(sys_clk), .rst(rst), .req(req),
		.f_chan(f_chan), .f_bits(f_bits), .f_len(f_len), .f_per(f_per),
		.rx_ready(rx_ready), .rx_valid(rx_valid), .rx_chan(rx_chan), .rx_bits(rx_bits),
		.rx_len(rx_len), .rx_period(rx_period));

	initial begin
		forever #10 sys_clk = ~sys_clk;
	end

	// ========================================
	// helpers
	task final_report;
		if (err_total == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic await(ref logic s, input logic v, input int n);
		int k;
		k = 0;
		#1;
		while (s !== v && k < n) begin
			@(posedge sys_clk);
			#1;
			k++;
		end
		if (s !== v) begin
			err_total++;
			$display("ERROR handshake exp %h got %h", v, s);
			final_report();
		end
	endtask
	task cfg(input logic [1:0] c, input logic [15:0] w);
		@(posedge sys_clk);
		cmd_valid <= 1;
		cmd_chan  <= c;
		cmd_word  <= w;
		@(posedge sys_clk);
		cmd_valid <= 0;
		@(negedge sys_clk);
	endtask
	task send(input logic [1:0] c, input logic [17:0] b, input logic [4:0] l,
		input logic [15:0] p);
		await(rx_valid, 1'b0, 40);
		@(posedge sys_clk);
		req    <= 1;
		f_chan <= c;
		f_bits <= b;
		f_len  <= l;
		f_per  <= p;
		@(posedge sys_clk);
		req <= 0;
	endtask
	task get(input logic [1:0] c, input logic [2:0] es, input logic [15:0] ew);
		await(dw_valid, 1'b1, 150);
		`CHK("dw_chan", c, dw_chan)
		`CHK("dw_status", es, dw_status)
		`CHK("dw_word", ew, dw_word)
		@(posedge sys_clk);
		dw_ready <= 1;
		@(posedge sys_clk);
		dw_ready <= 0;
	endtask
	task frame(input logic [1:0] c, input logic [17:0] b, input logic [4:0] l,
		input logic [15:0] p, input logic [2:0] es, input logic [15:0] ew);
		send(c, b, l, p);
		get(c, es, ew);
	endtask
	function automatic logic [17:0] gb(input logic [12:0] d, input logic bad);
		return {4'b0010, d, (^d) ^ bad};
	endfunction
	function automatic logic [15:0] ew(input logic [12:0] d);
		return {~^d, d, 2'b00};
	endfunction
	function automatic logic [2:0] crc_a(input logic [12:0] d);
		logic [2:0] r;
		r = CRC_SEED;
		for (int i = 12; i >= 0; i--) begin
			r = {r[1:0], 1'b0} ^ ((r[2] ^ d[i]) ? CRC_POLY : 3'h0);
		end
		return r;
	endfunction

	// ========================================
	// scenarios
	task t_reset;
		`CHK("sat_on", 4'h0, sat_on)
		`CHK("speed_code", 8'h00, speed_code)
		`CHK("thr_code", 12'h000, thr_code)
		`CHK("hyst_on", 4'h0, hyst_on)
		`CHK("dw_valid", 1'b0, dw_valid)
		`CHK("dec_on", 4'h0, dec_on)
		`CHK("dw_status", ST_EMPTY, dw_status)
		`CHK("dw_word", 16'h0000, dw_word)
		`CHK("rx_ready", 1'b1, rx_ready)
		`CHK("cmd_ready", 1'b1, cmd_ready)
	endtask
	task t_setup;
		for (int i = 0; i < 4; i++) begin
			cfg(3, 16'((i << 6) | (i << 4) | 8 | (7 - i)));
			`CHK("sat_on", (i != 0), sat_on[3])
			`CHK("dec_on", (i == 2), dec_on[3])
			`CHK("speed_code", 2'(i), speed_code[3])
			`CHK("thr_code", 3'(7 - i), thr_code[3])
			`CHK("hyst_on", 1'b1, hyst_on[3])
			`CHK("sat_on_other", 3'h0, sat_on[2:0])
		end
	endtask
	task t_frames;
		for (int c = 0; c < 4; c++) begin
			cfg(2'(c), 16'h0010);
			cfg(2'(c), 16'h0020);
		end
		frame(0, gb(13'h1a5b, 0), 16, 500, ST_GOOD, ew(13'h1a5b));
		frame(0, gb(13'h1a5b, 1), 16, 500, ST_BAD, 16'h0000);
		@(posedge sys_clk);
		leak_supply <= 4'h1;
		repeat (8) @(posedge sys_clk);
		frame(0, gb(13'h0a0a, 0), 16, 500, ST_LEAK_GOOD, ew(13'h0a0a));
		leak_supply <= 4'h0;
		repeat (8) @(posedge sys_clk);
		frame(0, gb(13'h1a5b, 0), 16, 100, ST_BAD, 16'h0000);
		frame(0, gb(13'h1a5b, 0), 15, 500, ST_BAD, 16'h0000);
		frame(2, gb(13'h0c3d, 0), 16, 500, ST_GOOD, ew(13'h0c3d));
		cfg(2, 16'h0820);
		frame(2, gb(13'h0c3d, 1), 16, 500, ST_BAD, 16'h0000);
		cfg(3, 16'h0620);
		frame(3, gb(13'h0777, 0), 16, 500, ST_GOOD, ew(13'h0777));
		cfg(0, 16'h0e20);
		frame(0, {7'h0, 2'h2, 9'h15a}, 11, 500, ST_GOOD, {9'h15a, 7'h0});
		cfg(1, 16'h0820);
		frame(1, {2'h2, 16'hbeef}, 18, 500, ST_GOOD, 16'hbeef);
		cfg(1, 16'h0e20);
		frame(1, {5'h0, 2'h2, 11'h5a5}, 13, 500, ST_GOOD, {11'h5a5, 5'h0});
		cfg(1, 16'h0020);
		frame(1, {2'h2, 13'h1234, crc_a(13'h1234)}, 18, 500, ST_GOOD, ew(13'h1234));
		frame(1, {2'h2, 13'h1234, ~crc_a(13'h1234)}, 18, 500, ST_BAD, 16'h0000);
	endtask
	task t_buffer;
		cfg(0, 16'h0020);
		for (int k = 0; k < 3; k++) send(0, gb(13'h0100 + 13'(k), 0), 16, 500);
		repeat (3) @(posedge sys_clk);
		`CHK("rx_ready", 1'b0, rx_ready)
		get(0, ST_GOOD, ew(13'h0100));
		get(0, ST_GOOD, ew(13'h0101));
		get(0, ST_LOST, ew(13'h0102));
	endtask
	task t_raw;
		cfg(0, 16'h0010);
		@(posedge sys_clk);
		cur_above <= 4'h1;
		get(0, ST_EMPTY, 16'h0000);
		@(posedge sys_clk);
		cur_above <= 4'h0;
		get(0, ST_EMPTY, 16'h0001);
		cfg(0, 16'h0018);
		@(posedge sys_clk);
		cur_above <= 4'h1;
		repeat (80) @(posedge sys_clk);
		`CHK("dw_valid_hyst", 1'b0, dw_valid)
		cur_above_hyst <= 4'h1;
		get(0, ST_EMPTY, 16'h0000);
		cfg(0, 16'h0030);
		send(0, gb(13'h0100, 0), 16, 500);
		@(posedge sys_clk);
		cur_above      <= 4'h0;
		cur_above_hyst <= 4'h0;
		repeat (120) @(posedge sys_clk);
		`CHK("dw_valid", 1'b0, dw_valid)
	endtask

	// ========================================
	// main sequence
	initial begin
		repeat (10) @(posedge sys_clk);
		rst <= 0;
		@(negedge sys_clk);
		t_reset();
		t_setup();
		t_frames();
		t_buffer();
		t_raw();
		final_report();
	end
endmodule
